// ### sim/rdsw_config_regs_properties.sv
`timescale 1ns/1ps
module rdsw_regs_chk
  import rdsw_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_OUT,
  input  wire logic       SDA_OE_OUT,
  input  wire logic       MODE_CONTROL_PIN_IN,
  input  rdsw_mode_t      SWITCH_MODE_OUT,
  input  wire logic       USB_ENABLE_OUT,
  input  wire logic       DISPLAY_ENABLE_OUT,
  input  wire logic [3:0] LANE_ENABLE_OUT,
  input  rdsw_eq_t        EQ_OUT,
  input  rdsw_aux_t       AUX_ROUTE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence scl_low_s; !SCL_IN ##1 !SCL_IN; endsequence
  sequence ack_rise_s; $rose(SDA_OE_OUT); endsequence
  reset_state_a: assert property ($rose(RST_N_IN) |-> SWITCH_MODE_OUT == RDSW_MODE_USB
    && USB_ENABLE_OUT && !DISPLAY_ENABLE_OUT && LANE_ENABLE_OUT == 4'h0 && EQ_OUT == '0 && AUX_ROUTE_OUT == '0)
    else $error("reset outputs wrong");
  usb_mode_a: assert property (USB_ENABLE_OUT == (SWITCH_MODE_OUT inside {RDSW_MODE_USB, RDSW_MODE_DP2_USB}))
    else $error("usb enable does not match mode");
  two_lane_a: assert property ((SWITCH_MODE_OUT == RDSW_MODE_DP2_USB)[*3] |-> LANE_ENABLE_OUT[3:2] == 2'b00)
    else $error("upper lanes on in two lane mode");
  lanes_off_a: assert property ((!DISPLAY_ENABLE_OUT)[*3] |-> LANE_ENABLE_OUT == 4'h0)
    else $error("lanes on while display off");
  display_src_a: assert property ((!MODE_CONTROL_PIN_IN && !SWITCH_MODE_OUT[1])[*4] |-> !DISPLAY_ENABLE_OUT)
    else $error("display enabled without source");
  aux_pair_a: assert property (AUX_ROUTE_OUT.auxn_sb1 == AUX_ROUTE_OUT.auxp_sb2
    && AUX_ROUTE_OUT.auxn_sb2 == AUX_ROUTE_OUT.auxp_sb1 && !(AUX_ROUTE_OUT.auxn_sb1 && AUX_ROUTE_OUT.auxn_sb2))
    else $error("aux route not a legal pairing");
  open_drain_a: assert property (SDA_OE_OUT |-> !SDA_OUT) else $error("data pin driven high");
  ack_launch_a: assert property (ack_rise_s |-> $past(SCL_IN, 2) == 1'b0 ##0 scl_low_s)
    else $error("data pull while clock high");
  ack_release_a: assert property ($fell(SDA_OE_OUT) |-> !SCL_IN && $past(SCL_IN, 2) == 1'b0)
    else $error("data release while clock high");
  ack_hold_a: assert property (ack_rise_s |-> SDA_OE_OUT[*8]) else $error("data pull too short");
endmodule
bind rdsw_config_regs rdsw_regs_chk i_rdsw_regs_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .MODE_CONTROL_PIN_IN(MODE_CONTROL_PIN_IN),
  .SWITCH_MODE_OUT(SWITCH_MODE_OUT), .USB_ENABLE_OUT(USB_ENABLE_OUT), .DISPLAY_ENABLE_OUT(DISPLAY_ENABLE_OUT),
  .LANE_ENABLE_OUT(LANE_ENABLE_OUT), .EQ_OUT(EQ_OUT), .AUX_ROUTE_OUT(AUX_ROUTE_OUT));

// ### sim/rdsw_i2c_host.sv
`timescale 1ns/1ps
module rdsw_i2c_host #(
  parameter int HALF_CYCLES = 8
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Start when s is set, stop otherwise
  task automatic frame(input logic s);
    pause(2);
    sda_low_out = !s;
    pause(HALF_CYCLES);
    scl_out = 1'b1;
    pause(HALF_CYCLES);
    sda_low_out = s;
    pause(HALF_CYCLES);
    if (s) scl_out = 1'b0;
  endtask
  task automatic clock_bit(input logic b, output logic seen);
    pause(2);
    sda_low_out = !b;
    pause(HALF_CYCLES);
    scl_out = 1'b1;
    pause(HALF_CYCLES);
    seen = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, d, output logic ack);
    logic a0, a1, a2;
    frame(1'b1);
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    frame(1'b0);
    ack = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d, output logic ack);
    logic a0, a1, a2, s;
    frame(1'b1);
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    frame(1'b1);
    send_byte({dev, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(1'b1, s);
    frame(1'b0);
    ack = a0 & a1 & a2;
  endtask
endmodule

// ### sim/rdsw_tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rdsw_pkg::*;
;
  logic        clk, rst_n, scl, host_low, mode_pin, sda_o, sda_oe, sda_wire, usb_en, disp_en, flip;
  logic [3:0]  lanes;
  rdsw_auxwr_t aux;
  rdsw_mode_t  mode;
  rdsw_eq_t    eq;
  rdsw_aux_t   route;
  int          err_total, check_count, cycle_count;
  assign sda_wire = !(host_low || (sda_oe && !sda_o));
  rdsw_config_regs i_rdsw_config_regs (.CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .MODE_CONTROL_PIN_IN(mode_pin), .DISPLAY_EQ_STRAPS_IN(2'b10),
    .USB_EQ_STRAPS_IN(2'b01), .UPSTREAM_EQ_STRAPS_IN(2'b11), .AUX_WR_IN(aux), .SWITCH_MODE_OUT(mode),
    .USB_ENABLE_OUT(usb_en), .DISPLAY_ENABLE_OUT(disp_en), .ORIENTATION_FLIP_OUT(flip),
    .LANE_ENABLE_OUT(lanes), .EQ_OUT(eq), .AUX_ROUTE_OUT(route));
  rdsw_i2c_host i_rdsw_i2c_host (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(host_low));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, d);
    logic a;
    i_rdsw_i2c_host.write_reg(7'h12, ofs, d, a);
    check("write_ack", a, 1);
  endtask
  task automatic rd(input logic [7:0] ofs, exp);
    logic [7:0] v;
    logic a;
    i_rdsw_i2c_host.read_reg(7'h12, ofs, v, a);
    check("read_ack", a, 1);
    check("reg_read", v, exp);
  endtask
  task automatic snoop(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 aux = {1'b1, a, d};
    @(posedge clk);
    #1 aux.valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    check("mode", mode, RDSW_MODE_USB);
    rd(8'h0a, 8'h01);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h10, 8'h22);
    rd(8'h11, 8'h22);
    rd(8'h20, 8'h11);
    rd(8'h21, 8'h03);
    check("eq", eq, 28'h2222113);
  endtask
  task automatic t_eq;
    wr(8'h10, 8'h5a);
    wr(8'h11, 8'hc3);
    wr(8'h20, 8'h96);
    wr(8'h21, 8'hff);
    rd(8'h10, 8'h22);
    wr(8'h0a, 8'h11);
    rd(8'h10, 8'h5a);
    rd(8'h11, 8'hc3);
    rd(8'h20, 8'h96);
    rd(8'h21, 8'h0f);
    check("eq", eq, 28'hc53a69f);
  endtask
  task automatic t_mode;
    logic a;
    for (int m = 0; m < 4; m++) begin
      wr(8'h0a, 8'(m));
      check("mode", mode, m);
      check("usb_en", usb_en, m % 2);
      check("disp_en", disp_en, m / 2);
    end
    wr(8'h0a, 8'h0c);
    mode_pin = 1'b1;
    repeat (5) @(posedge clk);
    #1 check("disp_en", disp_en, 1);
    check("flip", flip, 1);
    mode_pin = 1'b0;
    repeat (5) @(posedge clk);
    #1 check("disp_en", disp_en, 0);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h1f);
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    i_rdsw_i2c_host.write_reg(7'h13, 8'h0a, 8'h01, a);
    check("foreign_ack", a, 0);
    rd(8'h0a, 8'h1f);
  endtask
  task automatic t_snoop;
    wr(8'h0a, 8'h02);
    snoop(20'h00600, 8'h01);
    snoop(20'h00101, 8'h04);
    rd(8'h12, 8'h24);
    check("lanes", lanes, 4'hf);
    snoop(20'h00101, 8'h02);
    check("lanes", lanes, 4'h3);
    snoop(20'h00101, 8'h04);
    wr(8'h0a, 8'h03);
    check("lanes", lanes, 4'h3);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h24);
    wr(8'h0a, 8'h02);
    wr(8'h13, 8'h05);
    check("lanes", lanes, 4'hf);
    wr(8'h13, 8'h85);
    check("lanes", lanes, 4'ha);
    snoop(20'h00600, 8'h02);
    check("lanes", lanes, 4'ha);
    rd(8'h12, 8'h44);
    wr(8'h13, 8'h00);
    check("lanes", lanes, 4'h0);
    wr(8'h0a, 8'h01);
    rd(8'h12, 8'h00);
  endtask
  task automatic t_aux;
    logic [7:0] gen[6] = '{8'h02, 8'h06, 8'h01, 8'h01, 8'h06, 8'h02};
    logic [7:0] ctl[6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h30};
    logic [3:0] exp[6] = '{4'h3, 4'hc, 4'h0, 4'hc, 4'h3, 4'h0};
    for (int i = 0; i < 6; i++) begin
      wr(8'h0a, gen[i]);
      wr(8'h13, ctl[i]);
      check("route", route, exp[i]);
    end
    wr(8'h13, 8'hff);
    rd(8'h13, 8'hbf);
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 60000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    rst_n = 1'b0;
    mode_pin = 1'b0;
    aux = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    t_reset;
    t_eq;
    t_mode;
    t_snoop;
    t_aux;
    tally_and_finish;
  end
endmodule

// ### src/rdsw_config_regs.sv
`timescale 1ns/1ps
`include "rdsw_defines.svh"
module rdsw_config_regs
  import rdsw_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `RDSW_I2C_ADDR
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  input  wire logic        MODE_CONTROL_PIN_IN,
  input  wire logic [1:0]  DISPLAY_EQ_STRAPS_IN,
  input  wire logic [1:0]  USB_EQ_STRAPS_IN,
  input  wire logic [1:0]  UPSTREAM_EQ_STRAPS_IN,
  input  rdsw_auxwr_t      AUX_WR_IN,
  output rdsw_mode_t       SWITCH_MODE_OUT,
  output logic             USB_ENABLE_OUT,
  output logic             DISPLAY_ENABLE_OUT,
  output logic             ORIENTATION_FLIP_OUT,
  output logic [3:0]       LANE_ENABLE_OUT,
  output rdsw_eq_t         EQ_OUT,
  output rdsw_aux_t        AUX_ROUTE_OUT
);

  if (TARGET_ADDR < 7'h08 || TARGET_ADDR > 7'h77) begin : g_bad_addr
    $error("TARGET_ADDR lies in a reserved I2C range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] mpin_q;
  logic [5:0] strap_s1_q;
  logic [5:0] strap_s2_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      scl_q      <= 3'h7;
      sda_q      <= 3'h7;
      mpin_q     <= 2'h0;
      strap_s1_q <= 6'h00;
      strap_s2_q <= 6'h00;
    end else begin
      scl_q      <= {scl_q[1:0], SCL_IN};
      sda_q      <= {sda_q[1:0], SDA_IN};
      mpin_q     <= {mpin_q[0], MODE_CONTROL_PIN_IN};
      strap_s1_q <= {DISPLAY_EQ_STRAPS_IN, USB_EQ_STRAPS_IN, UPSTREAM_EQ_STRAPS_IN};
      strap_s2_q <= strap_s1_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign i2c_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign i2c_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release

  logic [1:0] strap_cnt_q;
  logic [5:0] strap_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      strap_cnt_q <= 2'h0;
      strap_q     <= 6'h00;
    end else if (strap_cnt_q != `RDSW_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q + 2'h1 == `RDSW_STRAP_WAIT) begin
        strap_q <= strap_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C target

  rdsw_i2c_st_t st_q;
  logic [3:0]   bit_cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   tx_q;
  logic [7:0]   ptr_q;
  logic         rw_q;
  logic         nack_q;
  logic         sda_oe_q;
  logic [7:0]   rd_data;
  logic         bus_wr;

  assign bus_wr = scl_fall & (st_q == RDSW_ST_WDATA) & (bit_cnt_q == 4'h8);

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      st_q      <= RDSW_ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (i2c_start) begin
      st_q      <= RDSW_ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else if (i2c_stop) begin
      st_q     <= RDSW_ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == RDSW_ST_ADDR || st_q == RDSW_ST_PTR || st_q == RDSW_ST_WDATA) begin
        shift_q   <= {shift_q[6:0], sda_q[2]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (st_q == RDSW_ST_RDATA_ACK) begin
        nack_q <= sda_q[2];
      end
    end else if (scl_fall) begin
      unique case (st_q)
        RDSW_ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        RDSW_ST_ADDR: begin
          if (bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == TARGET_ADDR) begin // [RL20]
              st_q     <= RDSW_ST_ADDR_ACK;
              rw_q     <= shift_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              st_q <= RDSW_ST_IDLE;
            end
          end
        end
        RDSW_ST_ADDR_ACK, RDSW_ST_RDATA_ACK: begin
          bit_cnt_q <= 4'h0;
          if (st_q == RDSW_ST_RDATA_ACK && nack_q) begin
            st_q     <= RDSW_ST_IDLE;
            sda_oe_q <= 1'b0;
          end else if (st_q == RDSW_ST_RDATA_ACK || rw_q) begin
            st_q     <= RDSW_ST_RDATA;
            tx_q     <= rd_data;
            sda_oe_q <= ~rd_data[7];
            ptr_q    <= ptr_q + 8'h01;
          end else begin
            st_q     <= RDSW_ST_PTR;
            sda_oe_q <= 1'b0;
          end
        end
        RDSW_ST_PTR: begin
          if (bit_cnt_q == 4'h8) begin
            st_q     <= RDSW_ST_PTR_ACK;
            ptr_q    <= shift_q;
            sda_oe_q <= 1'b1;
          end
        end
        RDSW_ST_PTR_ACK, RDSW_ST_WDATA_ACK: begin
          st_q      <= RDSW_ST_WDATA;
          bit_cnt_q <= 4'h0;
          sda_oe_q  <= 1'b0;
          if (st_q == RDSW_ST_WDATA_ACK) begin
            ptr_q <= ptr_q + 8'h01;
          end
        end
        RDSW_ST_WDATA: begin
          if (bit_cnt_q == 4'h8) begin
            st_q     <= RDSW_ST_WDATA_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        RDSW_ST_RDATA: begin
          if (bit_cnt_q == 4'h7) begin
            st_q     <= RDSW_ST_RDATA_ACK;
            sda_oe_q <= 1'b0;
          end else begin
            tx_q      <= {tx_q[6:0], 1'b0};
            sda_oe_q  <= ~tx_q[6];
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  assign SDA_OUT    = 1'b0;
  assign SDA_OE_OUT = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  function automatic logic [7:0] reg_merge(input logic [7:0] old, input logic [7:0] wd,
                                           input logic [7:0] wm, input logic [7:0] sm,
                                           input logic [7:0] cm);
    reg_merge = ((old & ~wm) | (wd & wm) | (wd & sm)) & ~(wd & cm); // [RL1] [RL2]
  endfunction

  logic [7:0] gen_q;
  logic [7:0] eq13_q;
  logic [7:0] eq02_q;
  logic [7:0] ctl_q;
  logic [7:0] usbeq_q;
  logic [7:0] upeq_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      gen_q   <= `RDSW_RST_GEN; // [RL4]
      eq13_q  <= `RDSW_RST_ZERO;
      eq02_q  <= `RDSW_RST_ZERO;
      ctl_q   <= `RDSW_RST_ZERO;
      usbeq_q <= `RDSW_RST_ZERO;
      upeq_q  <= `RDSW_RST_ZERO;
    end else if (bus_wr) begin
      unique case (ptr_q)
        `RDSW_OFS_GEN:   gen_q   <= reg_merge(gen_q, shift_q, `RDSW_WM_GEN, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE); // [RL21]
        `RDSW_OFS_EQ13:  eq13_q  <= reg_merge(eq13_q, shift_q, `RDSW_WM_ALL, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE);
        `RDSW_OFS_EQ02:  eq02_q  <= reg_merge(eq02_q, shift_q, `RDSW_WM_ALL, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE);
        `RDSW_OFS_CTL:   ctl_q   <= reg_merge(ctl_q, shift_q, `RDSW_WM_CTL, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE);
        `RDSW_OFS_USBEQ: usbeq_q <= reg_merge(usbeq_q, shift_q, `RDSW_WM_ALL, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE);
        `RDSW_OFS_UPEQ:  upeq_q  <= reg_merge(upeq_q, shift_q, `RDSW_WM_UPEQ, `RDSW_SETCLR_NONE, `RDSW_SETCLR_NONE); // [RL11]
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AUX snooping

  logic [1:0] pwr_q;
  logic [4:0] lanes_q;
  logic       mode1_prev_q;
  logic       mode1_fall;

  assign mode1_fall = mode1_prev_q & ~gen_q[`RDSW_GEN_MODE1];

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pwr_q        <= 2'h0;
      lanes_q      <= 5'h00;
      mode1_prev_q <= 1'b0;
    end else begin
      mode1_prev_q <= gen_q[`RDSW_GEN_MODE1];
      if (AUX_WR_IN.valid && AUX_WR_IN.addr == `RDSW_DPCD_PWR) begin
        pwr_q <= AUX_WR_IN.data[1:0]; // [RL3] [RL12]
      end else if (mode1_fall) begin
        pwr_q <= 2'h0; // [RL14]
      end
      if (AUX_WR_IN.valid && AUX_WR_IN.addr == `RDSW_DPCD_LANES) begin
        lanes_q <= AUX_WR_IN.data[4:0]; // [RL13]
      end else if (mode1_fall) begin
        lanes_q <= 5'h00; // [RL14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic       eq_ovr;
  logic [7:0] eq13_eff;
  logic [7:0] eq02_eff;
  logic [7:0] usbeq_eff;
  logic [3:0] upeq_eff;

  assign eq_ovr    = gen_q[`RDSW_GEN_EQOVR];
  assign eq13_eff  = eq_ovr ? eq13_q : {2'h0, strap_q[5:4], 2'h0, strap_q[5:4]}; // [RL6] [RL8]
  assign eq02_eff  = eq_ovr ? eq02_q : {2'h0, strap_q[5:4], 2'h0, strap_q[5:4]}; // [RL9]
  assign usbeq_eff = eq_ovr ? usbeq_q : {2'h0, strap_q[3:2], 2'h0, strap_q[3:2]}; // [RL10]
  assign upeq_eff  = eq_ovr ? upeq_q[3:0] : {2'h0, strap_q[1:0]}; // [RL11]

  always_comb begin
    unique case (ptr_q)
      `RDSW_OFS_GEN:   rd_data = gen_q;
      `RDSW_OFS_EQ13:  rd_data = eq13_eff;
      `RDSW_OFS_EQ02:  rd_data = eq02_eff;
      `RDSW_OFS_SNOOP: rd_data = {1'b0, pwr_q, lanes_q}; // [RL21]
      `RDSW_OFS_CTL:   rd_data = ctl_q;
      `RDSW_OFS_USBEQ: rd_data = usbeq_eff;
      `RDSW_OFS_UPEQ:  rd_data = {4'h0, upeq_eff};
      default:         rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch control outputs

  logic       dp_en;
  logic       snoop_en;
  logic [3:0] mode_lanes;
  logic [3:0] snoop_lanes;
  logic [3:0] lane_en;
  rdsw_aux_t  aux_route;

  assign dp_en      = gen_q[`RDSW_GEN_DPSRC] ? mpin_q[1] : gen_q[`RDSW_GEN_MODE1]; // [RL7]
  assign mode_lanes = !dp_en ? 4'h0 : (gen_q[0] ? 4'h3 : 4'hf); // [RL5]
  assign snoop_en   = ~ctl_q[`RDSW_CTL_SNPDIS]; // [RL15]

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      snoop_lanes[i] = (pwr_q == `RDSW_PWR_ON) && (5'(i) < lanes_q); // [RL12] [RL13]
    end
  end

  assign lane_en = mode_lanes & (snoop_en ? snoop_lanes : ~ctl_q[3:0]); // [RL16]

  always_comb begin
    aux_route = '0;
    unique case (ctl_q[5:4])
      2'h1: begin
        aux_route.auxn_sb1 = 1'b1; // [RL17]
        aux_route.auxp_sb2 = 1'b1;
      end
      2'h2: begin
        aux_route.auxn_sb2 = 1'b1; // [RL17]
        aux_route.auxp_sb1 = 1'b1;
      end
      2'h3: aux_route = '0; // [RL18]
      2'h0: begin
        if (gen_q[`RDSW_GEN_MODE1]) begin // [RL18] [RL19]
          aux_route.auxn_sb1 = gen_q[`RDSW_GEN_FLIP];
          aux_route.auxp_sb2 = gen_q[`RDSW_GEN_FLIP];
          aux_route.auxn_sb2 = ~gen_q[`RDSW_GEN_FLIP];
          aux_route.auxp_sb1 = ~gen_q[`RDSW_GEN_FLIP];
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      SWITCH_MODE_OUT      <= RDSW_MODE_USB;
      USB_ENABLE_OUT       <= 1'b1;
      DISPLAY_ENABLE_OUT   <= 1'b0;
      ORIENTATION_FLIP_OUT <= 1'b0;
      LANE_ENABLE_OUT      <= 4'h0;
      EQ_OUT               <= '0;
      AUX_ROUTE_OUT        <= '0;
    end else begin
      SWITCH_MODE_OUT      <= rdsw_mode_t'(gen_q[1:0]); // [RL5]
      USB_ENABLE_OUT       <= gen_q[0];
      DISPLAY_ENABLE_OUT   <= dp_en;
      ORIENTATION_FLIP_OUT <= gen_q[`RDSW_GEN_FLIP]; // [RL19]
      LANE_ENABLE_OUT      <= lane_en;
      EQ_OUT               <= {eq02_eff[7:4], eq13_eff[7:4], eq02_eff[3:0], eq13_eff[3:0],
                               usbeq_eff[3:0], usbeq_eff[7:4], upeq_eff};
      AUX_ROUTE_OUT        <= aux_route;
    end
  end

endmodule

// ### src/rdsw_defines.svh
// Functional notes
// RL1 - A one written to a set-type field sets it; a zero leaves it alone.
// RL2 - A one written to a clear-type field clears it; a zero leaves it alone.
// RL3 - Update-type fields may change by hardware action without any software write.
// RL4 - General control resets to 0x01; every other register resets to 0x00.
// RL5 - Mode field: 00 all off, 01 USB only, 10 four display lanes, 11 two lanes plus USB.
// RL6 - Override bit 4 picks straps (clear) or programmed values (set) for equalization.
// RL7 - Bit 3 picks display enable from mode upper bit (clear) or mode pin (set).
// RL8 - Register 0x10 holds lane 1 (7:4) and lane 3 (3:0) equalization.
// RL9 - Register 0x11 holds lane 0 (7:4) and lane 2 (3:0) equalization.
// RL10 - Register 0x20 holds second (7:4) and first (3:0) USB receiver equalization.
// RL11 - Register 0x21 bits 3:0 hold upstream equalization; bits 7:4 reserved, read-only.
// RL12 - AUX writes to 0x00600 are captured into power state bits 6:5 and steer lanes.
// RL13 - AUX writes to 0x00101 are captured into lane count bits 4:0 and steer lanes.
// RL14 - Both snooped fields clear when the mode upper bit falls from one to zero; a field hit by an AUX write in that cycle takes the write instead.
// RL15 - Register 0x13 bit 7 low enables snooping; high takes lanes from disable bits.
// RL16 - Disable bits 3:0 turn off lanes only while snooping is disabled.
// RL17 - Sideband override 01 and 10 force fixed AUX crossings regardless of mode or flip.
// RL18 - Override 00 follows mode and flip; override 11 opens all AUX paths.
// RL19 - Bit 2 is the orientation flip select, reset zero, used with mode for routing.
// RL20 - Bank is reached over I2C at target address 0x12 with straps floating.
// RL21 - Reserved bits read zero and ignore writes; snooped fields ignore writes.
`ifndef RDSW_DEFINES_SVH
`define RDSW_DEFINES_SVH
`define RDSW_I2C_ADDR     7'h12
`define RDSW_OFS_GEN      8'h0a
`define RDSW_OFS_EQ13     8'h10
`define RDSW_OFS_EQ02     8'h11
`define RDSW_OFS_SNOOP    8'h12
`define RDSW_OFS_CTL      8'h13
`define RDSW_OFS_USBEQ    8'h20
`define RDSW_OFS_UPEQ     8'h21
`define RDSW_RST_GEN      8'h01
`define RDSW_RST_ZERO     8'h00
`define RDSW_WM_GEN       8'h1f
`define RDSW_WM_ALL       8'hff
`define RDSW_WM_CTL       8'hbf
`define RDSW_WM_UPEQ      8'h0f
`define RDSW_SETCLR_NONE  8'h00
`define RDSW_GEN_EQOVR    4
`define RDSW_GEN_DPSRC    3
`define RDSW_GEN_FLIP     2
`define RDSW_GEN_MODE1    1
`define RDSW_CTL_SNPDIS   7
`define RDSW_DPCD_PWR     20'h00600
`define RDSW_DPCD_LANES   20'h00101
`define RDSW_PWR_ON       2'h1
`define RDSW_STRAP_WAIT   2'h3
`endif

// ### src/rdsw_pkg.sv
package rdsw_pkg;
  typedef enum logic [1:0] {
    RDSW_MODE_OFF,
    RDSW_MODE_USB,
    RDSW_MODE_DP4,
    RDSW_MODE_DP2_USB
  } rdsw_mode_t;

  typedef struct packed {
    logic [3:0] lane0;
    logic [3:0] lane1;
    logic [3:0] lane2;
    logic [3:0] lane3;
    logic [3:0] usb_rx_first;
    logic [3:0] usb_rx_second;
    logic [3:0] upstream_rx;
  } rdsw_eq_t;

  typedef struct packed {
    logic auxn_sb1;
    logic auxp_sb2;
    logic auxn_sb2;
    logic auxp_sb1;
  } rdsw_aux_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] addr;
    logic [7:0]  data;
  } rdsw_auxwr_t;

  typedef enum logic [3:0] {
    RDSW_ST_IDLE,
    RDSW_ST_ADDR,
    RDSW_ST_ADDR_ACK,
    RDSW_ST_PTR,
    RDSW_ST_PTR_ACK,
    RDSW_ST_WDATA,
    RDSW_ST_WDATA_ACK,
    RDSW_ST_RDATA,
    RDSW_ST_RDATA_ACK
  } rdsw_i2c_st_t;
endpackage
